// [src/ddrs_port.sv]
// Behaviour
// - write words captured on both input clock rises
// - read words launched on both input clock rises
// - data drivers off whenever no read word
// - load strobe low starts cycle, sampled on rise
// - every access moves exactly two words
// - lane selects sampled with their write word
// - select n gates nine-bit lane n
// - deselected lane leaves stored bits unchanged
// - shared address sampled on positive clock rise
// - storage is two equal banks
// - direction high reads, low writes, when loading
// - read valid marks driven words, echo aligned
// - termination range latched once after power up
// - accesses start only on positive clock rise
// - complementary clock rise captures and launches data
// - echo clocks run free, follow positive clock
// - loop off gives one cycle read latency
`timescale 1ns/1ps
`default_nettype none

module ddrs_port (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        ref_edge_pos_i,
  input  wire logic                        ref_edge_neg_i,
  input  wire logic                        load_strobe_n_i,
  input  wire logic                        rnw_dir_i,
  input  wire logic [ddrs_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [ddrs_pkg::LANES-1:0]  byte_write_sel_n_i,
  input  wire logic [ddrs_pkg::DATA_W-1:0] io_word_i,
  output logic      [ddrs_pkg::DATA_W-1:0] io_word_o,
  output logic                             io_word_oe_o,
  output logic                             read_valid_o,
  output logic                             echo_clk_o,
  output logic                             echo_clk_n_o,
  input  wire logic                        pll_off_n_i,
  input  wire logic                        term_range_sel_i,
  output logic                             term_range_high_o,
  output logic                             write_overflow_o
);

  ddrs_pkg::ddrs_pins_type     pin_raw;
  ddrs_pkg::ddrs_pins_type     sync1;
  ddrs_pkg::ddrs_pins_type     sync2;
  logic                        k_d;
  logic                        kn_d;
  logic                        pos_tick;
  logic                        neg_tick;
  logic                        tick;
  logic                        pll_on;
  ddrs_pkg::ddrs_wr_state_type wr_state;
  logic [ddrs_pkg::ADDR_W-1:0] wr_addr;
  logic                        wr_pend;
  logic [ddrs_pkg::ADDR_W-1:0] pend_addr;
  logic                        wr_load;
  logic                        rd_issue;
  logic                        rd_ret;
  logic                        push;
  ddrs_pkg::ddrs_wr_entry_type push_entry;
  logic                        fifo_in_ready;
  logic                        fifo_out_valid;
  logic                        fifo_out_ready;
  ddrs_pkg::ddrs_wr_entry_type drain_entry;
  logic [ddrs_pkg::ENTRY_W-1:0] drain_bits;
  logic [ddrs_pkg::ADDR_W-1:0] ram_addr;
  logic [ddrs_pkg::DATA_W-1:0] ram_rdata [ddrs_pkg::BANKS];
  ddrs_pkg::ddrs_rd_stage_type pipe [ddrs_pkg::PIPE_LEN];
  ddrs_pkg::ddrs_rd_stage_type src_w0;
  ddrs_pkg::ddrs_rd_stage_type src_w1;
  logic [1:0]                  term_cnt;
  logic                        term_done;

  // gather the pins into one group for the synchroniser
  always_comb begin
    pin_raw.k         = ref_edge_pos_i;
    pin_raw.kn        = ref_edge_neg_i;
    pin_raw.load_n    = load_strobe_n_i;
    pin_raw.rnw       = rnw_dir_i;
    pin_raw.addr      = addr_i;
    pin_raw.bws_n     = byte_write_sel_n_i;
    pin_raw.d         = io_word_i;
    pin_raw.pll_off_n = pll_off_n_i;
    pin_raw.term      = term_range_sel_i;
  end

  // two flip-flop synchroniser; all pins see the same delay
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1           <= '0;
      sync1.kn        <= 1'b1;
      sync1.load_n    <= 1'b1;
      sync1.bws_n     <= '1;
      sync1.pll_off_n <= 1'b1;
      sync1.term      <= 1'b1;
      sync2           <= '0;
      sync2.kn        <= 1'b1;
      sync2.load_n    <= 1'b1;
      sync2.bws_n     <= '1;
      sync2.pll_off_n <= 1'b1;
      sync2.term      <= 1'b1;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
    end
  end

  // rising edge detection on both input clocks
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      k_d  <= 1'b0;
      kn_d <= 1'b1;                                         // idles high
    end else begin
      k_d  <= sync2.k;
      kn_d <= sync2.kn;
    end
  end

  assign pos_tick = sync2.k && !k_d;
  assign neg_tick = sync2.kn && !kn_d && !pos_tick;
  assign tick     = pos_tick || neg_tick;
  assign pll_on   = sync2.pll_off_n;

  // commands are taken only on a positive clock rise with the strobe low
  assign wr_load  = pos_tick && !sync2.load_n && !sync2.rnw;
  assign rd_issue = pos_tick && !sync2.load_n && sync2.rnw;

  // write burst tracking: first word on next positive rise, second on
  // the complementary rise after it; a load during a burst is queued
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_state  <= ddrs_pkg::WR_IDLE;
      wr_addr   <= '0;
      wr_pend   <= 1'b0;
      pend_addr <= '0;
    end else if (pos_tick) begin
      case (wr_state)
        ddrs_pkg::WR_IDLE: begin
          if (wr_load) begin
            wr_state <= ddrs_pkg::WR_W0;
            wr_addr  <= sync2.addr;
          end
        end
        ddrs_pkg::WR_W0: begin
          wr_state <= ddrs_pkg::WR_W1;
          if (wr_load) begin
            wr_pend   <= 1'b1;
            pend_addr <= sync2.addr;
          end
        end
        default: begin
          if (wr_load) begin
            wr_pend   <= 1'b1;
            pend_addr <= sync2.addr;
          end
        end
      endcase
    end else if (neg_tick && wr_state == ddrs_pkg::WR_W1) begin
      if (wr_pend) begin
        wr_state <= ddrs_pkg::WR_W0;
        wr_addr  <= pend_addr;
        wr_pend  <= 1'b0;
      end else begin
        wr_state <= ddrs_pkg::WR_IDLE;
      end
    end
  end

  // capture one word per clock rise together with its lane selects
  always_comb begin
    push                = 1'b0;
    push_entry.bank     = 1'b0;
    push_entry.addr     = wr_addr;
    push_entry.lane_en  = ~sync2.bws_n;
    push_entry.data     = sync2.d;
    if (pos_tick && wr_state == ddrs_pkg::WR_W0) begin
      push = 1'b1;
    end else if (neg_tick && wr_state == ddrs_pkg::WR_W1) begin
      push            = 1'b1;
      push_entry.bank = 1'b1;
    end
  end

  // a word that meets a full buffer is lost; flag it until reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      write_overflow_o <= 1'b0;
    end else if (push && !fifo_in_ready) begin
      write_overflow_o <= 1'b1;
    end
  end

  ddrs_fifo #(
    .WIDTH (ddrs_pkg::ENTRY_W),
    .DEPTH (ddrs_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_i       (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_entry),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (drain_bits)
  );

  // reads own the array port; buffered writes drain when it is free
  assign drain_entry    = drain_bits;
  assign fifo_out_ready = !rd_issue;
  assign ram_addr       = rd_issue ? sync2.addr : drain_entry.addr;

  // two equal banks: first burst word in bank 0, second in bank 1
  for (genvar b = 0; b < ddrs_pkg::BANKS; b++) begin : g_bank
    ddrs_ram #(
      .ADDR_W (ddrs_pkg::ADDR_W),
      .DATA_W (ddrs_pkg::DATA_W),
      .LANE_W (ddrs_pkg::LANE_W)
    ) u_ram (
      .clk_i     (ref_clk_i),
      .addr_i    (ram_addr),
      .wr_en_i   (fifo_out_valid && fifo_out_ready
                  && (drain_entry.bank == 1'(b))),
      .lane_en_i (drain_entry.lane_en),
      .wdata_i   (drain_entry.data),
      .rdata_o   (ram_rdata[b])
    );
  end

  // read return lands one cycle after the issue
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_ret <= 1'b0;
    end else begin
      rd_ret <= rd_issue;
    end
  end

  // half-cycle read pipeline: shifts on every clock rise
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < ddrs_pkg::PIPE_LEN; i++) begin
        pipe[i] <= '0;
      end
    end else if (tick) begin
      pipe[0]     <= '0;
      pipe[0].vld <= rd_issue;
      for (int i = 1; i < ddrs_pkg::PIPE_LEN; i++) begin
        pipe[i] <= pipe[i-1];
      end
    end else if (rd_ret) begin
      pipe[0].w0 <= ram_rdata[0];
      pipe[0].w1 <= ram_rdata[1];
    end
  end

  // launch points depend on whether the internal loop runs
  always_comb begin
    if (pll_on) begin
      src_w0 = pipe[ddrs_pkg::RD_LAT_PLL_HT-1];
      src_w1 = pipe[ddrs_pkg::RD_LAT_PLL_HT];
    end else begin
      src_w0 = pipe[ddrs_pkg::RD_LAT_OFF_HT-1];
      src_w1 = pipe[ddrs_pkg::RD_LAT_OFF_HT];
    end
  end

  // output word, driver enable and valid change together on each rise
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_word_o    <= '0;
      io_word_oe_o <= 1'b0;
      read_valid_o <= 1'b0;
    end else if (tick) begin
      if (src_w0.vld) begin
        io_word_o    <= src_w0.w0;
        io_word_oe_o <= 1'b1;
        read_valid_o <= 1'b1;
      end else if (src_w1.vld) begin
        io_word_o    <= src_w1.w1;
        io_word_oe_o <= 1'b1;
        read_valid_o <= 1'b1;
      end else begin
        io_word_oe_o <= 1'b0;
        read_valid_o <= 1'b0;
      end
    end
  end

  // echo clocks follow the positive clock every cycle, frames or not
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      echo_clk_o   <= 1'b0;
      echo_clk_n_o <= 1'b1;
    end else begin
      echo_clk_o   <= sync2.k;
      echo_clk_n_o <= !sync2.k;
    end
  end

  // termination strap taken once, after the synchroniser has filled
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      term_cnt          <= '0;
      term_done         <= 1'b0;
      term_range_high_o <= 1'b1;
    end else if (!term_done) begin
      if (term_cnt == ddrs_pkg::TERM_WAIT) begin
        term_range_high_o <= sync2.term;
        term_done         <= 1'b1;
      end else begin
        term_cnt <= term_cnt + 2'h1;
      end
    end
  end

  // ---- assertions ----
  sequence s_w0_due;
    tick && src_w0.vld;
  endsequence

  sequence s_nothing_due;
    tick && !src_w0.vld && !src_w1.vld;
  endsequence

  a_read_first_word: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_w0_due |=> io_word_oe_o && io_word_o == $past(src_w0.w0))
    else $error("first read word not launched");

  a_pll_latency: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    tick && pll_on && pipe[4].vld && !pipe[3].vld |=> io_word_oe_o
      && io_word_o == $past(pipe[4].w0))
    else $error("loop-on read latency wrong");

  a_dll_latency: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    tick && !pll_on && pipe[1].vld |=> io_word_oe_o
      && io_word_o == $past(pipe[1].w0))
    else $error("loop-off read latency wrong");

  a_idle_hiz: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_nothing_due |=> !io_word_oe_o)
    else $error("drivers on with no read word");

  a_valid_tracks_oe: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    read_valid_o == io_word_oe_o)
    else $error("read valid differs from driver enable");

  a_echo_follow: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(sync2.k) |=> echo_clk_o && !echo_clk_n_o)
    else $error("echo clock does not follow input clock");

  a_issue_on_rise: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_issue |-> pos_tick && !fifo_out_ready)
    else $error("read issued off a positive rise");

  a_write_first: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    pos_tick && wr_state == ddrs_pkg::WR_W0 |->
      push && !push_entry.bank ##1 wr_state == ddrs_pkg::WR_W1)
    else $error("first write word not captured");

  a_write_pair: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    push && push_entry.bank |-> neg_tick
      && wr_state == ddrs_pkg::WR_W1)
    else $error("second write word out of burst");

  a_lane_sample: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    push |-> push_entry.lane_en == ~sync2.bws_n
      && push_entry.data == sync2.d)
    else $error("lane selects not sampled with word");

  a_term_hold: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    term_done |=> $stable(term_range_high_o))
    else $error("termination range changed after latch");

endmodule

`default_nettype wire

// [src/ddrs_pkg.sv]
package ddrs_pkg;

  // array geometry of the narrow variant
  localparam int ADDR_W     = 19;
  localparam int DATA_W     = 18;
  localparam int LANE_W     = 9;
  localparam int LANES      = DATA_W / LANE_W;
  localparam int BANKS      = 2;

  // write buffer depth in words
  localparam int FIFO_DEPTH = 32;

  // read latency in half cycles of the input clock pair
  localparam int RD_LAT_PLL_HT = 5;
  localparam int RD_LAT_OFF_HT = 2;
  localparam int PIPE_LEN      = RD_LAT_PLL_HT + 1;

  // cycles after reset release before the termination strap is taken
  localparam logic [1:0] TERM_WAIT = 2'h3;

  // synchronised pin group
  typedef struct packed {
    logic                      k;
    logic                      kn;
    logic                      load_n;
    logic                      rnw;
    logic [ADDR_W-1:0]         addr;
    logic [LANES-1:0]          bws_n;
    logic [DATA_W-1:0]         d;
    logic                      pll_off_n;
    logic                      term;
  } ddrs_pins_type;

  // one buffered write word
  typedef struct packed {
    logic                      bank;
    logic [ADDR_W-1:0]         addr;
    logic [LANES-1:0]          lane_en;
    logic [DATA_W-1:0]         data;
  } ddrs_wr_entry_type;

  localparam int ENTRY_W = 1 + ADDR_W + LANES + DATA_W;

  // one read burst travelling toward the output
  typedef struct packed {
    logic                      vld;
    logic [DATA_W-1:0]         w0;
    logic [DATA_W-1:0]         w1;
  } ddrs_rd_stage_type;

  // write burst tracking, gray along idle -> first -> second
  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_W0   = 2'h1,
    WR_W1   = 2'h3
  } ddrs_wr_state_type;

endpackage

// [src/ddrs_store.sv]
`timescale 1ns/1ps
`default_nettype none

// single port storage array with lane write enables and registered read
module ddrs_ram #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 18,
  parameter int LANE_W = 9
) (
  input  wire logic                       clk_i,
  input  wire logic [ADDR_W-1:0]          addr_i,
  input  wire logic                       wr_en_i,
  input  wire logic [DATA_W/LANE_W-1:0]   lane_en_i,
  input  wire logic [DATA_W-1:0]          wdata_i,
  output var  logic [DATA_W-1:0]          rdata_o
);
  localparam int LANES = DATA_W / LANE_W;

  logic [DATA_W-1:0] mem [2**ADDR_W];

  // lane i gates bits i*9+8 down to i*9; untouched lanes keep their value
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      for (int i = 0; i < LANES; i++) begin
        if (lane_en_i[i]) begin
          mem[addr_i][i*LANE_W +: LANE_W] <= wdata_i[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // read data out of a register
  always_ff @(posedge clk_i) begin
    rdata_o <= mem[addr_i];
  end
endmodule

// first-in first-out buffer with valid and ready on both sides
module ddrs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // honest full and empty from the occupancy count
  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

`default_nettype wire

// [sim/ddrs_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none

// memory controller model: input clock pair, loads and write words
module ddrs_ctrl_model (
  input  wire logic                        clk_i,
  input  wire logic                        run_i,
  output logic                             k_o,
  output logic                             kn_o,
  output logic                             load_n_o,
  output logic                             rnw_o,
  output logic      [ddrs_pkg::ADDR_W-1:0] addr_o,
  output logic      [ddrs_pkg::LANES-1:0]  bws_n_o,
  output logic      [ddrs_pkg::DATA_W-1:0] d_o,
  input  wire logic [ddrs_pkg::DATA_W-1:0] q_i,
  input  wire logic                        oe_i,
  input  wire logic                        vld_i
);
  logic [2:0]  phase;
  int          hc;
  int          nf;
  logic [19:0] cmd [int];
  logic [19:0] wr [int];
  int          rq_t [$];
  logic [19:0] rq_w [$];

  // quiet pins until the clock pair is started
  initial begin
    phase = 3'h4;
    hc = 0;
    nf = 0;
    k_o = 1'b0;
    kn_o = 1'b1;
    load_n_o = 1'b1;
    rnw_o = 1'b1;
    addr_o = '0;
    bws_n_o = 2'h3;
    d_o = '0;
  end

  // book a load on a free K rise; write words follow on the next K rise and the Kn rise after it
  task automatic issue(input logic rd, input logic [18:0] a,
                       input logic [19:0] w0, input logic [19:0] w1,
                       output int t);
    t = (nf > hc + 3) ? nf : hc + 3;
    if (t % 2 == 0) t++;
    cmd[t] = {rd, a};
    if (!rd) begin
      wr[t + 2] = w0;
      wr[t + 3] = w1;
    end
    nf = t + 2;
  endtask

  // pins change two cycles before the rise that samples them
  always @(negedge clk_i) begin
    if (!run_i) begin
      // park so the first rise is a counted K rise with an odd count
      phase <= 3'h4;
      hc <= hc + hc % 2;
      k_o <= 1'b0;
      kn_o <= 1'b1;
      load_n_o <= 1'b1;
    end else begin
      phase <= phase + 3'h1;
      k_o <= (phase == 3'h7) || (phase < 3'h3);
      kn_o <= (phase >= 3'h3) && (phase != 3'h7);
      if (phase == 3'h7 || phase == 3'h3)
        hc <= hc + 1;
      if (phase == 3'h5 || phase == 3'h1) begin
        load_n_o <= !cmd.exists(hc + 1);
        if (cmd.exists(hc + 1))
          {rnw_o, addr_o} <= cmd[hc + 1];
        else
          {rnw_o, addr_o} <= ~{rnw_o, addr_o};
        if (wr.exists(hc + 1))
          {bws_n_o, d_o} <= wr[hc + 1];
        else begin
          bws_n_o <= 2'h3;
          d_o <= ~d_o;
        end
        if (oe_i === 1'b1 || vld_i === 1'b1) begin
          rq_t.push_back(hc - 1);
          rq_w.push_back({vld_i, oe_i, q_i});
        end
      end
    end
  end
endmodule

`default_nettype wire

// [sim/ddr_burst2_sram_port_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module ddr_burst2_sram_port_bench;
  logic ref_clk, rst_n, run, pll_off_n, term;
  logic k, kn, load_n, rnw, oe, vld, echo, echo_n, term_high, ovf;
  logic [18:0] addr;
  logic [1:0]  bws_n;
  logic [17:0] ctrl_d, q, io_word_in;
  int          fail_count = 0;
  int          total_checks = 0;

  // shared data wire: device drives while enabled
  assign io_word_in = oe ? q : ctrl_d;

  ddrs_port u_ddrs_port (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
    .ref_edge_pos_i(k), .ref_edge_neg_i(kn), .load_strobe_n_i(load_n),
    .rnw_dir_i(rnw), .addr_i(addr), .byte_write_sel_n_i(bws_n),
    .io_word_i(io_word_in), .io_word_o(q), .io_word_oe_o(oe),
    .read_valid_o(vld), .echo_clk_o(echo), .echo_clk_n_o(echo_n),
    .pll_off_n_i(pll_off_n), .term_range_sel_i(term),
    .term_range_high_o(term_high), .write_overflow_o(ovf));

  ddrs_ctrl_model u_ddrs_ctrl_model (.clk_i(ref_clk), .run_i(run),
    .k_o(k), .kn_o(kn), .load_n_o(load_n), .rnw_o(rnw), .addr_o(addr),
    .bws_n_o(bws_n), .d_o(ctrl_d), .q_i(q), .oe_i(oe), .vld_i(vld));

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // wait for a given count of input clock rises, bounded
  task automatic wait_tick(input int n);
    for (int i = 0; i < 400 && u_ddrs_ctrl_model.hc < n; i++)
      @(negedge ref_clk);
    if (u_ddrs_ctrl_model.hc < n) begin
      fail_count++;
      wrap_up();
    end
  endtask

  // reset with a given strap, then start the clock pair
  task automatic do_reset(input logic strap);
    run = 1'b0;
    term = strap;
    rst_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    check({term_high, oe, vld, echo, echo_n}, 5'h11, "reset outs");
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    run = 1'b1;
    repeat (4) @(negedge ref_clk);
    check(term_high, strap, "strap");
  endtask

  // pop the two words of one read and judge value, tick and valid
  task automatic rd_expect(input int t, input int lat,
                           input logic [17:0] e0, input logic [17:0] e1);
    wait_tick(t + lat + 3);
    for (int j = 0; j < 2; j++) begin
      if (u_ddrs_ctrl_model.rq_t.size() == 0)
        check(0, 1, "read word missing");
      else begin
        check(u_ddrs_ctrl_model.rq_t.pop_front(), t + lat + j, "tick");
        check(u_ddrs_ctrl_model.rq_w.pop_front(), {2'h3, j ? e1 : e0},
              "read word");
      end
    end
  endtask

  // echo pair follows the positive clock while idle; strap stays latched
  task automatic idle_run();
    term = 1'b1;
    for (int j = 0; j < 40; j++) begin
      @(negedge ref_clk);
      if (u_ddrs_ctrl_model.phase == 3'h3)
        check({echo, echo_n}, 2'h2, "echo high");
      if (u_ddrs_ctrl_model.phase == 3'h7)
        check({echo, echo_n}, 2'h1, "echo low");
    end
    check(term_high, 1'b0, "strap relatched");
  endtask

  // back to back writes, then back to back reads, top address included
  task automatic rw_run();
    int ta;
    int tb;
    u_ddrs_ctrl_model.issue(1'b0, 19'h0_0005, {2'h0, 18'h2_a5c3},
                            {2'h0, 18'h1_5a3c}, ta);
    u_ddrs_ctrl_model.issue(1'b0, 19'h7_ffff, {2'h0, 18'h3_ffff},
                            {2'h0, 18'h0_0001}, tb);
    wait_tick(tb + 6);
    u_ddrs_ctrl_model.issue(1'b1, 19'h0_0005, '0, '0, ta);
    u_ddrs_ctrl_model.issue(1'b1, 19'h7_ffff, '0, '0, tb);
    rd_expect(ta, 5, 18'h2_a5c3, 18'h1_5a3c);
    rd_expect(tb, 5, 18'h3_ffff, 18'h0_0001);
  endtask

  // one lane per word deselected, read back with the loop off
  task automatic lane_run();
    int t;
    u_ddrs_ctrl_model.issue(1'b0, 19'h0_0005, {2'h2, 18'h0_0000},
                            {2'h1, 18'h3_ffff}, t);
    wait_tick(t + 6);
    pll_off_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    u_ddrs_ctrl_model.issue(1'b1, 19'h0_0005, '0, '0, t);
    rd_expect(t, 2, 18'h2_a400, 18'h3_fe3c);
    wait_tick(t + 8);
    pll_off_n = 1'b1;
    wait_tick(t + 12);
    check(u_ddrs_ctrl_model.rq_t.size(), 0, "stray words");
    check(ovf, 1'b0, "overflow");
  endtask

  // eight back to back bursts through the write buffer, read in order
  task automatic fifo_run();
    int t [8];
    for (int j = 0; j < 8; j++)
      u_ddrs_ctrl_model.issue(1'b0, 19'h0_0010 + 19'(j),
                              {2'h0, 18'h0_1111 * 18'(j)},
                              {2'h0, ~(18'h0_1111 * 18'(j))}, t[j]);
    wait_tick(t[7] + 6);
    check(ovf, 1'b0, "buffer refused a word");
    for (int j = 0; j < 8; j++)
      u_ddrs_ctrl_model.issue(1'b1, 19'h0_0010 + 19'(j), '0, '0, t[j]);
    for (int j = 0; j < 8; j++)
      rd_expect(t[j], 5, 18'h0_1111 * 18'(j),
                ~(18'h0_1111 * 18'(j)));
    wait_tick(t[7] + 12);
    check(u_ddrs_ctrl_model.rq_t.size(), 0, "buffer stray");
  endtask

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // hang guard
  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    run = 1'b0;
    pll_off_n = 1'b1;
    term = 1'b0;
    do_reset(1'b0);
    idle_run();
    rw_run();
    lane_run();
    do_reset(1'b1);
    fifo_run();
    wrap_up();
  end
endmodule

`default_nettype wire
